// File: verilog/debug_test_access_port.sv
/*
  boundary-scan tap with debug control, trace status and pc trace output.
  assumes tck, tms, tdi, trst_n arrive synchronous to core_clk_i, which is
  much faster than tck; edges of tck are detected in the core domain.
*/
// Overview of operation
// R1: test clock independent, sampled for edges
// R2: shift tdi into ir or dr on rise
// R3: tdo changes on falling test clock edge
// R4: tdo high impedance unless shifting
// R5: tms sampled on rise, drives tap states
// R6: idle: host holds trst low or tms high
// R7: trace mode: tdi low stops real-time trace
// R8: trace mode: tdo emits non-sequential pc values
// R9: debug mode reassigns tdi and tdo pins
// R10: trace capture clock from divided core clock
// R11: three-bit pipeline trace status output
// R12: debug boot forces debug exception, break bit
// R13: sixteen-state tap, trst resets asynchronously; here trst_n is sampled and applied on the next core clock edge
`timescale 1ns/1ns
`default_nettype none
module debug_test_access_port (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic dclk_o,
  output logic [2:0] pcst_o,
  input wire logic debug_boot_i,
  input wire logic reset_seq_end_i,
  output logic debug_exc_o,
  output logic reset_exc_o,
  output logic debug_int_o,
  input wire logic [2:0] pipe_status_i,
  input wire logic pc_valid_i,
  output logic pc_ready_o,
  input wire logic [31:0] pc_i
);
  logic rst_s1_reg;
  logic rst_n;
  logic tck_prev_reg;
  logic tck_rise;
  logic tck_fall;
  dbg_tap_pkg::tap_state_t state_reg;
  dbg_tap_pkg::tap_state_t state_next;
  logic [dbg_tap_pkg::IR_W-1:0] ir_sh_reg;
  logic [dbg_tap_pkg::IR_W-1:0] ir_reg;
  logic [dbg_tap_pkg::DR_W-1:0] dr_sh_reg;
  logic [dbg_tap_pkg::CTRL_W-1:0] ctrl_reg;
  logic trace_mode;
  logic trace_stop_reg;
  logic [3:0] div_cnt_reg;
  logic dclk_tick;
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic [31:0] pc_sh_reg;
  logic [5:0] pc_bits_reg;
  logic pc_take;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // tck is a plain sampled input, never a clock of its own [R1]
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_i;
    end
  end
  assign tck_rise = tck_i && !tck_prev_reg;
  assign tck_fall = !tck_i && tck_prev_reg;

  function automatic logic in_state(input dbg_tap_pkg::tap_state_t s,
                                    input dbg_tap_pkg::tap_state_t t);
    in_state = (s == t);
  endfunction : in_state

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dbg_tap_pkg::TLR: state_next = tms_i ? dbg_tap_pkg::TLR : dbg_tap_pkg::RTI;
      dbg_tap_pkg::RTI: state_next = tms_i ? dbg_tap_pkg::SEL_DR : dbg_tap_pkg::RTI;
      dbg_tap_pkg::SEL_DR: state_next = tms_i ? dbg_tap_pkg::SEL_IR : dbg_tap_pkg::CAP_DR;
      dbg_tap_pkg::CAP_DR: state_next = tms_i ? dbg_tap_pkg::EX1_DR : dbg_tap_pkg::SH_DR;
      dbg_tap_pkg::SH_DR: state_next = tms_i ? dbg_tap_pkg::EX1_DR : dbg_tap_pkg::SH_DR;
      dbg_tap_pkg::EX1_DR: state_next = tms_i ? dbg_tap_pkg::UPD_DR : dbg_tap_pkg::PA_DR;
      dbg_tap_pkg::PA_DR: state_next = tms_i ? dbg_tap_pkg::EX2_DR : dbg_tap_pkg::PA_DR;
      dbg_tap_pkg::EX2_DR: state_next = tms_i ? dbg_tap_pkg::UPD_DR : dbg_tap_pkg::SH_DR;
      dbg_tap_pkg::UPD_DR: state_next = tms_i ? dbg_tap_pkg::SEL_DR : dbg_tap_pkg::RTI;
      dbg_tap_pkg::SEL_IR: state_next = tms_i ? dbg_tap_pkg::TLR : dbg_tap_pkg::CAP_IR;
      dbg_tap_pkg::CAP_IR: state_next = tms_i ? dbg_tap_pkg::EX1_IR : dbg_tap_pkg::SH_IR;
      dbg_tap_pkg::SH_IR: state_next = tms_i ? dbg_tap_pkg::EX1_IR : dbg_tap_pkg::SH_IR;
      dbg_tap_pkg::EX1_IR: state_next = tms_i ? dbg_tap_pkg::UPD_IR : dbg_tap_pkg::PA_IR;
      dbg_tap_pkg::PA_IR: state_next = tms_i ? dbg_tap_pkg::EX2_IR : dbg_tap_pkg::PA_IR;
      dbg_tap_pkg::EX2_IR: state_next = tms_i ? dbg_tap_pkg::UPD_IR : dbg_tap_pkg::SH_IR;
      dbg_tap_pkg::UPD_IR: state_next = tms_i ? dbg_tap_pkg::SEL_DR : dbg_tap_pkg::RTI;
    endcase
  end

  // trst_n acts on the next core clock edge, not on tck; it is synchronous to the core clock by assumption
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dbg_tap_pkg::TLR;
    end else if (!trst_n_i) begin
      state_reg <= dbg_tap_pkg::TLR; // [R13]
    end else if (tck_rise) begin
      state_reg <= state_next; // [R5] [R13]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_reg <= '0;
      ir_reg <= dbg_tap_pkg::IR_RESET;
    end else if (!trst_n_i || in_state(state_reg, dbg_tap_pkg::TLR)) begin
      ir_reg <= dbg_tap_pkg::IR_RESET;
    end else if (tck_rise) begin
      if (in_state(state_reg, dbg_tap_pkg::CAP_IR)) begin
        ir_sh_reg <= {{(dbg_tap_pkg::IR_W-2){1'b0}}, dbg_tap_pkg::IR_CAPTURE};
      end else if (in_state(state_reg, dbg_tap_pkg::SH_IR)) begin
        ir_sh_reg <= {tdi_i, ir_sh_reg[dbg_tap_pkg::IR_W-1:1]}; // [R2]
      end else if (in_state(state_reg, dbg_tap_pkg::UPD_IR)) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  // data register chain; bypass is one stage at bit 0, so tdo lags tdi by one
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dr_sh_reg <= '0;
    end else if (tck_rise && !trace_mode) begin
      if (in_state(state_reg, dbg_tap_pkg::CAP_DR)) begin
        unique case (ir_reg)
          dbg_tap_pkg::IR_IDCODE: dr_sh_reg <= dbg_tap_pkg::ID_VALUE;
          dbg_tap_pkg::IR_CONTROL: dr_sh_reg <= {16'h0000, ctrl_reg};
          default: dr_sh_reg <= '0;
        endcase
      end else if (in_state(state_reg, dbg_tap_pkg::SH_DR)) begin
        if (ir_reg == dbg_tap_pkg::IR_BYPASS) begin
          dr_sh_reg <= {31'h00000000, tdi_i}; // [R2]
        end else if (ir_reg == dbg_tap_pkg::IR_CONTROL) begin
          dr_sh_reg <= {16'h0000, tdi_i, dr_sh_reg[15:1]}; // [R2]
        end else begin
          dr_sh_reg <= {tdi_i, dr_sh_reg[31:1]}; // [R2]
        end
      end
    end
  end

  // break bit: debug boot set wins over a scan write clearing it
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= dbg_tap_pkg::CTRL_RESET;
    end else begin
      if (tck_rise && in_state(state_reg, dbg_tap_pkg::UPD_DR)
          && ir_reg == dbg_tap_pkg::IR_CONTROL) begin
        ctrl_reg <= dr_sh_reg[15:0];
      end
      if (debug_boot_i) begin
        ctrl_reg[dbg_tap_pkg::BRK_BIT] <= 1'b1; // [R12]
      end
    end
  end

  // debug boot is a level, not latched; the exceptions sample it only at reset end [R12]
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      debug_exc_o <= 1'b0;
      reset_exc_o <= 1'b0;
    end else begin
      debug_exc_o <= reset_seq_end_i && debug_boot_i; // [R12]
      reset_exc_o <= reset_seq_end_i && !debug_boot_i;
    end
  end

  // trace mode entered by instruction, left by a low tdi (interrupt)
  assign trace_mode = ((ir_reg == dbg_tap_pkg::IR_TRACE) || (ir_reg == dbg_tap_pkg::IR_DEBUG))
                      && !trace_stop_reg; // [R9]

  // the interrupt holds real-time work off until a new instruction lands
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trace_stop_reg <= 1'b0;
    end else if (trace_mode && !tdi_i) begin
      trace_stop_reg <= 1'b1; // [R7]
    end else if (!trst_n_i || (tck_rise && in_state(state_reg, dbg_tap_pkg::UPD_IR))) begin
      trace_stop_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      debug_int_o <= 1'b0;
    end else begin
      debug_int_o <= trace_mode && !tdi_i; // [R7] [R9]
    end
  end

  // divided core clock paces trace output; divider is a control field
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= dbg_tap_pkg::TRC_DIV_RESET;
      dclk_o <= 1'b0;
    end else if (!trace_mode) begin
      div_cnt_reg <= dbg_tap_pkg::TRC_DIV_RESET;
      dclk_o <= 1'b0;
    end else if (div_cnt_reg >= ctrl_reg[3:0]) begin
      div_cnt_reg <= dbg_tap_pkg::TRC_DIV_RESET;
      dclk_o <= !dclk_o; // [R10]
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end
  assign dclk_tick = trace_mode && dclk_o && div_cnt_reg >= ctrl_reg[3:0];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pcst_o <= dbg_tap_pkg::PCST_SEQ;
    end else if (ir_reg == dbg_tap_pkg::IR_DEBUG) begin
      pcst_o <= dbg_tap_pkg::PCST_DEBUG; // [R11]
    end else begin
      pcst_o <= pipe_status_i; // [R11]
    end
  end

  trace_fifo #(
    .WIDTH(dbg_tap_pkg::FIFO_W),
    .DEPTH(dbg_tap_pkg::FIFO_D)
  ) u_fifo (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(pc_valid_i && trace_mode),
    .in_ready_o(pc_ready_o),
    .in_data_i(pc_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pc_take),
    .out_data_o(fifo_data)
  );

  // a pc word is serialised lsb first, one bit per trace clock period
  assign pc_take = trace_mode && fifo_valid && pc_bits_reg == 6'h00;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_sh_reg <= '0;
      pc_bits_reg <= 6'h00;
    end else if (!trace_mode) begin
      pc_bits_reg <= 6'h00;
    end else if (pc_take) begin
      pc_sh_reg <= fifo_data; // [R8]
      pc_bits_reg <= 6'h20;
    end else if (dclk_tick && pc_bits_reg != 6'h00) begin
      pc_sh_reg <= {1'b0, pc_sh_reg[31:1]}; // [R8]
      pc_bits_reg <= pc_bits_reg - 6'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (trace_mode) begin
      tdo_o <= pc_sh_reg[0]; // [R8] [R9]
      tdo_oe_o <= pc_bits_reg != 6'h00;
    end else if (!trst_n_i) begin
      tdo_oe_o <= 1'b0; // [R4] [R13]
    end else if (tck_fall) begin
      tdo_o <= in_state(state_reg, dbg_tap_pkg::SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0]; // [R3]
      tdo_oe_o <= in_state(state_reg, dbg_tap_pkg::SH_IR)
                  || in_state(state_reg, dbg_tap_pkg::SH_DR); // [R4]
    end
  end
endmodule : debug_test_access_port
`default_nettype wire

// File: inc/dbg_tap_pkg.sv
/*
  constants for the debug and boundary-scan access port: tap states,
  instruction codes, register widths, trace status codes, trace divider.
  assumes a single core clock domain; the test clock is sampled as data.
*/
package dbg_tap_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int CTRL_W = 16;
  localparam int BRK_BIT = 12;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_CONTROL = 4'hA;
  localparam logic [3:0] IR_TRACE = 4'hB;
  localparam logic [3:0] IR_DEBUG = 4'hC;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  // arbitrary neutral identification value
  localparam logic [31:0] ID_VALUE = 32'h0000_0001;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  localparam logic [2:0] PCST_STALL = 3'h7;
  localparam logic [2:0] PCST_JMP_PC = 3'h6;
  localparam logic [2:0] PCST_JMP_NOPC = 3'h5;
  localparam logic [2:0] PCST_EXC = 3'h4;
  localparam logic [2:0] PCST_SEQ = 3'h3;
  localparam logic [2:0] PCST_TRC_STALL = 3'h2;
  localparam logic [2:0] PCST_TRC_TRIG = 3'h1;
  localparam logic [2:0] PCST_DEBUG = 3'h0;

  localparam int FIFO_W = 32;
  localparam int FIFO_D = 16;
  localparam logic [3:0] TRC_DIV_RESET = 4'h0;
endpackage : dbg_tap_pkg

// File: verilog/trace_fifo.sv
/*
  synchronous fifo for trace program counter words.
  assumes one clock; read data come from a register.
*/
`timescale 1ns/1ns
`default_nettype none
module trace_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_next;
  logic empty;
  logic do_wr;
  logic do_rd;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  // ready is the registered not-full of the next pointers, so the port is a flop
  assign do_wr = in_valid_i && in_ready_o;
  assign wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
  assign rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  // output register refills whenever it is empty or being drained
  assign do_rd = !empty && (!out_valid_o || out_ready_i);

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      in_ready_o <= 1'b0;
    end else begin
      in_ready_o <= !((wr_ptr_next[AW] != rd_ptr_next[AW])
                      && (wr_ptr_next[AW-1:0] == rd_ptr_next[AW-1:0]));
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data_o <= mem_reg[rd_ptr_reg[AW-1:0]];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule : trace_fifo
`default_nettype wire

// File: testbench/dbg_probe.sv
/*
  probe model for the test pins: drives tck, tms, tdi, trst_n; samples tdo.
  assumes it is paced by the core clock at the bench; in trace mode it
  captures tdo while the trace clock is low and tdo is driven.
*/
`timescale 1ns/1ns
`default_nettype none
module dbg_probe (
  input wire logic core_clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  input wire logic dclk_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  localparam int HALF = 4;
  logic trace_on = 1'b0;
  logic [31:0] cap_sh = 32'h00000000;
  int cap_bits = 0;
  int cap_words = 0;
  logic [31:0] cap_mem [20];
  // one trace bit per core clock while the trace clock is low, lsb first
  always @(posedge core_clk_i) begin
    if (trace_on && tdo_oe_i && !dclk_i) begin
      cap_sh = {tdo_i, cap_sh[31:1]};
      cap_bits++;
      if (cap_bits == 32) begin
        if (cap_words < 20) begin
          cap_mem[cap_words] = cap_sh;
        end
        cap_words++;
        cap_bits = 0;
      end
    end
  end
  // unused port: test reset low, tms and tdi at pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b0;
  end
  // equal phases; tms is set a whole phase ahead of the rise
  task automatic step(input logic m, input logic di, output logic [1:0] s);
    @(posedge core_clk_i);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= di;
    repeat (HALF) @(posedge core_clk_i);
    s = {tdo_oe_i, tdo_i};
    tck_o <= 1'b1;
    repeat (HALF - 1) @(posedge core_clk_i);
  endtask : step
  // lsb first; tms high on the last bit leaves the shift state
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout,
                       output logic oe_all);
    logic [1:0] s;
    dout = 32'h00000000;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], s);
      dout[i] = s[0];
      oe_all = oe_all & s[1];
    end
  endtask : shift
endmodule : dbg_probe
`default_nettype wire

// File: testbench/debug_test_access_port_sva.sv
/*
  port checker for the debug access port.
  assumes one core clock domain; bound to the top module.
*/
`timescale 1ns/1ns
`default_nettype none
module dbg_tap_checker (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic dclk_o,
  input wire logic [2:0] pcst_o,
  input wire logic debug_boot_i,
  input wire logic reset_seq_end_i,
  input wire logic debug_exc_o,
  input wire logic reset_exc_o,
  input wire logic debug_int_o,
  input wire logic [2:0] pipe_status_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_boot_dbg; reset_seq_end_i && debug_boot_i |=> debug_exc_o && !reset_exc_o; endproperty
  a_boot_dbg: assert property (p_boot_dbg) else $error("no debug exception");
  property p_boot_rst; reset_seq_end_i && !debug_boot_i |=> reset_exc_o && !debug_exc_o; endproperty
  a_boot_rst: assert property (p_boot_rst) else $error("no reset exception");
  property p_exc_quiet; !reset_seq_end_i |=> !debug_exc_o && !reset_exc_o; endproperty
  a_exc_quiet: assert property (p_exc_quiet) else $error("stray exception");
  property p_int_cause; debug_int_o |-> !$past(tdi_i); endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without tdi low");
  property p_int_clear; tdi_i |=> !debug_int_o; endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt stuck");
  property p_pcst; pcst_o != 3'h0 |-> pcst_o == $past(pipe_status_i); endproperty
  a_pcst: assert property (p_pcst) else $error("trace status mismatch");
  property p_trst; !trst_n_i [*4] |-> !tdo_oe_o && !dclk_o; endproperty
  a_trst: assert property (p_trst) else $error("drive during test reset");
  // trace output excluded: there tdo follows the trace clock
  property p_tdo_fall;
    $changed(tdo_o) && tdo_oe_o && $past(tdo_oe_o) && !dclk_o && !$past(dclk_o)
      && !$past(dclk_o, 2) |-> !$past(tck_i) && $past(tck_i, 2);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge");
  c_dbg_exc: cover property (debug_exc_o);
  c_int: cover property (debug_int_o);
  c_trace: cover property ($rose(dclk_o));
endmodule : dbg_tap_checker
bind debug_test_access_port dbg_tap_checker u_chk (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .tck_i(tck_i), .tdi_i(tdi_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .dclk_o(dclk_o), .pcst_o(pcst_o), .debug_boot_i(debug_boot_i),
  .reset_seq_end_i(reset_seq_end_i), .debug_exc_o(debug_exc_o),
  .reset_exc_o(reset_exc_o), .debug_int_o(debug_int_o), .pipe_status_i(pipe_status_i));
`default_nettype wire

// File: testbench/testbench.sv
/*
  bench for the debug access port: status, exceptions, idcode, trace, reset.
  assumes the probe model drives the test pins.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic core_clk_i, resetn_i, debug_boot_i, reset_seq_end_i, pc_valid_i, r, full_seen, oe_seen;
  logic [2:0] pipe_status_i;
  logic [31:0] pc_i, rnd, d;
  logic [1:0] s2;
  logic [31:0] sent [20];
  wire logic tck, tms, tdi, trst_n, tdo, tdo_oe, dclk, dbg_exc, rst_exc, dbg_int, pc_ready;
  wire logic [2:0] pcst;
  int n_errors = 0;
  int checks_done = 0;
  int t;
  debug_test_access_port dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .dclk_o(dclk), .pcst_o(pcst), .debug_boot_i(debug_boot_i),
    .reset_seq_end_i(reset_seq_end_i), .debug_exc_o(dbg_exc), .reset_exc_o(rst_exc),
    .debug_int_o(dbg_int), .pipe_status_i(pipe_status_i), .pc_valid_i(pc_valid_i),
    .pc_ready_o(pc_ready), .pc_i(pc_i));
  dbg_probe probe (.core_clk_i(core_clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .dclk_i(dclk), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [2:0] exp_pcst(input logic [2:0] p, input logic dbg);
    return dbg ? dbg_tap_pkg::PCST_DEBUG : p;
  endfunction : exp_pcst
  task automatic results();
    $display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic moves(input int n, input logic [7:0] m);
    for (int i = 0; i < n; i++) begin
      probe.step(m[i], 1'b1, s2);
    end
  endtask : moves
  task automatic load_ir(input logic [3:0] code);
    moves(4, 8'h03);
    probe.shift(4, {28'h0000000, code}, d, r);
    moves(2, 8'h01);
  endtask : load_ir
  // d[15:0] returns the control value captured before w is written
  task automatic ctrl_scan(input logic [15:0] w);
    load_ir(dbg_tap_pkg::IR_CONTROL);
    moves(3, 8'h01);
    probe.shift(16, {16'h0000, w}, d, r);
    moves(2, 8'h01);
  endtask : ctrl_scan
  task automatic read_id();
    moves(3, 8'h01);
    probe.shift(32, 32'hFFFFFFFF, d, r);
    `CHK("idcode", dbg_tap_pkg::ID_VALUE, d)
    `CHK("tdo_oe_o shifting", 1'b1, r)
    moves(2, 8'h01);
    repeat (4) @(posedge core_clk_i);
    `CHK("tdo_oe_o idle", 1'b0, tdo_oe)
    $display("test idcode done");
  endtask : read_id
  // random status codes reach every encoding; exit pulses never back to back
  task automatic pipe_run(input int n, input logic dbg);
    logic [2:0] p;
    logic e, bt;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      p = pipe_status_i;
      e = reset_seq_end_i;
      bt = debug_boot_i;
      rnd = lfsr_next(rnd);
      pipe_status_i <= rnd[2:0];
      reset_seq_end_i <= (rnd[7:4] == 4'h0) && !e;
      debug_boot_i <= rnd[8];
      @(negedge core_clk_i);
      `CHK("pcst_o", exp_pcst(p, dbg), pcst)
      `CHK("debug_exc_o", e & bt, dbg_exc)
      `CHK("reset_exc_o", e & ~bt, rst_exc)
    end
    @(posedge core_clk_i);
    $display("test status run done");
  endtask : pipe_run
  // valid held across words: acceptance is decided at the negedge before each rise
  task automatic push(input logic [31:0] w);
    pc_valid_i <= 1'b1;
    pc_i <= w;
    t = 0;
    do begin
      @(negedge core_clk_i);
      t++;
      full_seen = full_seen | !pc_ready;
      oe_seen = oe_seen | tdo_oe;
    end while (!pc_ready && t < 3000);
    @(posedge core_clk_i);
  endtask : push
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_errors++;
    results();
  end
  initial begin
    resetn_i = 1'b0;
    debug_boot_i = 1'b0;
    reset_seq_end_i = 1'b0;
    pc_valid_i = 1'b0;
    pipe_status_i = 3'h3;
    pc_i = 32'h00000000;
    rnd = 32'h67C53E2A;
    full_seen = 1'b0;
    oe_seen = 1'b0;
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    probe.trst_n_o <= 1'b1;
    pipe_run(300, 1'b0);
    debug_boot_i <= 1'b0;
    reset_seq_end_i <= 1'b0;
    moves(6, 8'h1F);
    read_id();
    ctrl_scan(16'h0000);
    debug_boot_i <= 1'b1;
    @(posedge core_clk_i);
    debug_boot_i <= 1'b0;
    rnd = lfsr_next(rnd);
    ctrl_scan(rnd[15:0]);
    `CHK("break_request_bit", 16'h0001 << dbg_tap_pkg::BRK_BIT, d[15:0])
    ctrl_scan(16'h0000);
    `CHK("control write", rnd[15:0], d[15:0])
    $display("test control done");
    load_ir(dbg_tap_pkg::IR_BYPASS);
    moves(3, 8'h01);
    rnd = lfsr_next(rnd);
    probe.shift(8, rnd, d, r);
    `CHK("bypass", {rnd[6:0], 1'b0}, d[7:0])
    moves(2, 8'h01);
    $display("test bypass done");
    load_ir(dbg_tap_pkg::IR_TRACE);
    probe.trace_on <= 1'b1;
    @(negedge core_clk_i);
    r = dclk;
    @(negedge core_clk_i);
    `CHK("dclk_o toggles", ~r, dclk)
    @(posedge core_clk_i);
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr_next(rnd);
      sent[i] = rnd;
      push(rnd);
    end
    pc_valid_i <= 1'b0;
    `CHK("pc_ready_o refuses when full", 1'b1, full_seen)
    `CHK("tdo_oe_o trace words", 1'b1, oe_seen)
    t = 0;
    while (probe.cap_words < 20 && t < 6000) begin
      @(posedge core_clk_i);
      t++;
    end
    `CHK("trace drained", 1'b1, t < 6000)
    `CHK("trace word count", 20, probe.cap_words)
    for (int i = 0; i < 20; i++) begin
      `CHK("trace word", sent[i], probe.cap_mem[i])
    end
    probe.trace_on <= 1'b0;
    probe.tdi_o <= 1'b0;
    repeat (2) @(negedge core_clk_i);
    `CHK("debug_int_o", 1'b1, dbg_int)
    @(posedge core_clk_i);
    probe.tdi_o <= 1'b1;
    @(negedge core_clk_i);
    r = dclk;
    @(negedge core_clk_i);
    `CHK("dclk_o stopped", 2'b00, {r, dclk})
    $display("test trace done");
    load_ir(dbg_tap_pkg::IR_DEBUG);
    pipe_run(100, 1'b1);
    probe.trst_n_o <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    `CHK("tdo_oe_o in test reset", 1'b0, tdo_oe)
    probe.trst_n_o <= 1'b1;
    moves(1, 8'h00);
    read_id();
    results();
  end
endmodule : testbench
`default_nettype wire
